// [inc/fault_status_pkg.sv]
// Purpose: Shared constants for the fault status and mask logic.
// Assumes: 13-bit register words, twelve bypass drivers.
// Notes:   Register offsets are the device's internal register indices.

package fault_status_pkg;

	localparam int DATA_W  = 13;
	localparam int ADDR_W  = 7;
	localparam int DRIVERS = 12;

	// -----------------------------------------------------------------
	// Register indices
	// -----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_GENERAL_CONFIG = 7'h03;
	localparam logic [ADDR_W-1:0] ADDR_FAULT_MASK     = 7'h04;
	localparam logic [ADDR_W-1:0] ADDR_GENERAL_STATUS = 7'h05;
	localparam logic [ADDR_W-1:0] ADDR_LAMP_OPEN      = 7'h06;

	// -----------------------------------------------------------------
	// Fault mask fields
	// -----------------------------------------------------------------
	localparam int MSK_HEAT_WARNING   = 0;
	localparam int MSK_OVERHEAT_ACT   = 1;
	localparam int MSK_PUMP_NOT_READY = 2;
	localparam int MSK_LAMP_SHORT     = 3;
	localparam int MSK_LAMP_OPEN      = 4;
	localparam int MSK_WIRING_BREAK   = 5;
	localparam int MSK_SERIAL_ERROR   = 6;
	localparam logic [DATA_W-1:0] MASK_USED  = 13'h007F;
	localparam logic [DATA_W-1:0] MASK_RESET = 13'h0000;

	// -----------------------------------------------------------------
	// General status fields
	// -----------------------------------------------------------------
	localparam int ST_HEAT_WARNING   = 0;
	localparam int ST_OVERHEAT       = 1;
	localparam int ST_PUMP_NOT_READY = 2;
	localparam int ST_LAMP_SHORT     = 3;
	localparam int ST_LAMP_OPEN      = 4;
	localparam int ST_WIRING_BREAK   = 5;
	localparam int ST_SERIAL_ERROR   = 6;
	localparam int ST_EXT_CLK_SLOW   = 7;
	localparam int ST_GRADE_PENDING  = 8;
	localparam int ST_CONFIG_BUSY    = 9;
	localparam int FAULT_BITS        = 8;

	// Clock select: upper code bit picks the external clock
	localparam int CLK_SEL_EXT_BIT = 1;

	localparam logic [DATA_W-1:0] ZERO_WORD = 13'h0000;

	typedef enum logic [1:0] {
		GRADE_PENDING = 2'b01,
		GRADE_VALID   = 2'b10
	} grade_state_t;

endpackage : fault_status_pkg

// [design/level_sync.sv]
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes: Inputs are slow levels; each bit is crossed on its own.
// Notes:   First stage is read only by the second stage.

`timescale 1ns/1ns
`default_nettype none

module level_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	// -----------------------------------------------------------------
	// Two stages
	// -----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			stage1   <= '0;
			sync_out <= '0;
		end
		else if (clk_en)
		begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : level_sync

`default_nettype wire

// [design/fault_status_mask.sv]
// Purpose: General status collection, fault masking and fault pin drive.
// Assumes: Register strobes come from the serial framer on this clock.
// Notes:   Read data is registered; read-clear acts on the read strobe.

`timescale 1ns/1ns
`default_nettype none

module fault_status_mask #(
	parameter int DRIVERS = fault_status_pkg::DRIVERS
) (
	input  wire logic                                clk,
	input  wire logic                                srst,
	input  wire logic                                clk_en,
	input  wire logic                                reg_wr,
	input  wire logic                                reg_rd,
	input  wire logic [fault_status_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [fault_status_pkg::DATA_W-1:0] reg_wdata,
	output var  logic [fault_status_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                                heat_warning,
	input  wire logic                                overheat_shutdown,
	input  wire logic                                pump_not_ready,
	input  wire logic                                external_clock_slow,
	input  wire logic                                serial_read_error,
	input  wire logic                                serial_write_error,
	input  wire logic                                serial_checksum_error,
	input  wire logic                                serial_clock_error,
	input  wire logic [DRIVERS-1:0]                  per_driver_wiring_break,
	input  wire logic [DRIVERS-1:0]                  per_driver_lamp_short,
	input  wire logic [DRIVERS-1:0]                  lamp_open_detect,
	input  wire logic [1:0]                          pwm_clock_select,
	input  wire logic                                config_applied,
	input  wire logic                                grade_read_done,
	output var  logic [DRIVERS-1:0]                  per_driver_lamp_open,
	output var  logic                                grade_valid,
	output var  logic                                fault_out_n,
	output var  logic                                fault_pin_out,
	output var  logic                                fault_pin_oe_n,
	output var  logic                                switch_force_closed,
	output var  logic                                switch_force_open
);

	// -----------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------
	logic [fault_status_pkg::DATA_W-1:0] fault_mask_config;
	logic [fault_status_pkg::DATA_W-1:0] general_status;
	logic [fault_status_pkg::DATA_W-1:0] next_rdata;
	logic [3:0]                          async_raw;
	logic [3:0]                          async_sync;
	logic                                heat_warning_s;
	logic                                overheat_shutdown_s;
	logic                                pump_not_ready_s;
	logic                                external_clock_slow_s;
	logic                                heat_warning_flag;
	logic                                overheat_flag;
	logic                                config_busy;
	logic                                serial_error;
	logic                                ext_clk_selected;
	logic                                wr_mask;
	logic                                wr_config;
	logic                                rd_status;
	logic                                rd_lamp_open;
	logic [fault_status_pkg::FAULT_BITS-1:0] fault_src;
	logic [fault_status_pkg::FAULT_BITS-1:0] fault_gate;
	logic                                next_fault;
	fault_status_pkg::grade_state_t      grade_state;

	// -----------------------------------------------------------------
	// Synchronise analog and pin conditions
	// -----------------------------------------------------------------
	assign async_raw = {external_clock_slow, pump_not_ready,
		overheat_shutdown, heat_warning};

	level_sync #(
		.WIDTH (4)
	) u_cond_sync (
		.clk      (clk),
		.srst     (srst),
		.clk_en   (clk_en),
		.async_in (async_raw),
		.sync_out (async_sync)
	);

	assign heat_warning_s        = async_sync[0];
	assign overheat_shutdown_s   = async_sync[1];
	assign pump_not_ready_s      = async_sync[2];
	assign external_clock_slow_s = async_sync[3];

	// -----------------------------------------------------------------
	// Access decode
	// -----------------------------------------------------------------
	always_comb
	begin
		wr_mask      = 1'b0;
		wr_config    = 1'b0;
		rd_status    = 1'b0;
		rd_lamp_open = 1'b0;
		if (reg_addr == fault_status_pkg::ADDR_FAULT_MASK)
			wr_mask = reg_wr;
		else if (reg_addr == fault_status_pkg::ADDR_GENERAL_CONFIG)
			wr_config = reg_wr;
		else if (reg_addr == fault_status_pkg::ADDR_GENERAL_STATUS)
			rd_status = reg_rd; // Writes here fall through unused.
		else if (reg_addr == fault_status_pkg::ADDR_LAMP_OPEN)
			rd_lamp_open = reg_rd;
	end

	// -----------------------------------------------------------------
	// Fault mask register
	// -----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
			fault_mask_config <= fault_status_pkg::MASK_RESET;
		else if (clk_en && wr_mask)
			fault_mask_config <= reg_wdata & fault_status_pkg::MASK_USED;
	end

	// -----------------------------------------------------------------
	// Thermal latches
	// -----------------------------------------------------------------
	// Set term first: a still-present condition survives the read.
	always_ff @(posedge clk)
	begin
		if (srst)
			heat_warning_flag <= 1'b0;
		else if (clk_en)
		begin
			if (heat_warning_s)
				heat_warning_flag <= 1'b1;
			else if (rd_status)
				heat_warning_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			overheat_flag <= 1'b0;
		else if (clk_en)
		begin
			if (overheat_shutdown_s)
				overheat_flag <= 1'b1;
			else if (rd_status)
				overheat_flag <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Configuration busy
	// -----------------------------------------------------------------
	// A write landing with the done pulse keeps the bit set.
	always_ff @(posedge clk)
	begin
		if (srst)
			config_busy <= 1'b0;
		else if (clk_en)
		begin
			if (wr_config)
				config_busy <= 1'b1;
			else if (config_applied)
				config_busy <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Resistor grade readiness
	// -----------------------------------------------------------------
	// Grade is sampled once after power-up, so pending is the reset state.
	always_ff @(posedge clk)
	begin
		if (srst)
			grade_state <= fault_status_pkg::GRADE_PENDING;
		else if (clk_en)
		begin
			case (grade_state)
				fault_status_pkg::GRADE_PENDING:
				begin
					if (grade_read_done)
						grade_state <= fault_status_pkg::GRADE_VALID;
				end
				fault_status_pkg::GRADE_VALID:
					grade_state <= fault_status_pkg::GRADE_VALID;
				default:
					grade_state <= fault_status_pkg::GRADE_PENDING;
			endcase
		end
	end

	assign grade_valid = (grade_state == fault_status_pkg::GRADE_VALID);

	// -----------------------------------------------------------------
	// Per-driver lamp-open word
	// -----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < DRIVERS; gi = gi + 1)
		begin : g_lamp_open
			always_ff @(posedge clk)
			begin
				if (srst)
					per_driver_lamp_open[gi] <= 1'b0;
				else if (clk_en)
				begin
					if (lamp_open_detect[gi])
						per_driver_lamp_open[gi] <= 1'b1;
					else if (rd_lamp_open)
						per_driver_lamp_open[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// -----------------------------------------------------------------
	// General status word
	// -----------------------------------------------------------------
	assign serial_error = serial_read_error | serial_write_error |
		serial_checksum_error | serial_clock_error;
	assign ext_clk_selected =
		pwm_clock_select[fault_status_pkg::CLK_SEL_EXT_BIT];

	always_comb
	begin
		general_status = fault_status_pkg::ZERO_WORD;
		general_status[fault_status_pkg::ST_HEAT_WARNING] =
			heat_warning_flag;
		general_status[fault_status_pkg::ST_OVERHEAT] = overheat_flag;
		general_status[fault_status_pkg::ST_PUMP_NOT_READY] =
			pump_not_ready_s;
		general_status[fault_status_pkg::ST_LAMP_SHORT] =
			|per_driver_lamp_short;
		general_status[fault_status_pkg::ST_LAMP_OPEN] =
			|per_driver_lamp_open;
		general_status[fault_status_pkg::ST_WIRING_BREAK] =
			|per_driver_wiring_break;
		general_status[fault_status_pkg::ST_SERIAL_ERROR] = serial_error;
		general_status[fault_status_pkg::ST_EXT_CLK_SLOW] =
			ext_clk_selected & external_clock_slow_s;
		general_status[fault_status_pkg::ST_GRADE_PENDING] =
			~grade_valid;
		general_status[fault_status_pkg::ST_CONFIG_BUSY] = config_busy;
	end

	// -----------------------------------------------------------------
	// Fault masking
	// -----------------------------------------------------------------
	// Shutdown and slow external clock have no mask bit; slow clock reports only while the external clock is selected.
	always_comb
	begin
		fault_src  = general_status[fault_status_pkg::FAULT_BITS-1:0];
		fault_gate = '1;
		fault_gate[fault_status_pkg::ST_HEAT_WARNING] =
			~fault_mask_config[fault_status_pkg::MSK_HEAT_WARNING];
		fault_gate[fault_status_pkg::ST_PUMP_NOT_READY] =
			~fault_mask_config[fault_status_pkg::MSK_PUMP_NOT_READY];
		fault_gate[fault_status_pkg::ST_LAMP_SHORT] =
			~fault_mask_config[fault_status_pkg::MSK_LAMP_SHORT];
		fault_gate[fault_status_pkg::ST_LAMP_OPEN] =
			~fault_mask_config[fault_status_pkg::MSK_LAMP_OPEN];
		fault_gate[fault_status_pkg::ST_WIRING_BREAK] =
			~fault_mask_config[fault_status_pkg::MSK_WIRING_BREAK];
		fault_gate[fault_status_pkg::ST_SERIAL_ERROR] =
			~fault_mask_config[fault_status_pkg::MSK_SERIAL_ERROR];
		next_fault = |(fault_src & fault_gate);
	end

	// -----------------------------------------------------------------
	// Fault pin
	// -----------------------------------------------------------------
	// Registered so the open-drain pin never glitches on decode settling.
	always_ff @(posedge clk)
	begin
		if (srst)
			fault_out_n <= 1'b1;
		else if (clk_en)
			fault_out_n <= ~next_fault;
	end

	assign fault_pin_out  = 1'b0;
	assign fault_pin_oe_n = fault_out_n;

	// -----------------------------------------------------------------
	// Thermal shutdown switch action
	// -----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			switch_force_closed <= 1'b0;
			switch_force_open   <= 1'b0;
		end
		else if (clk_en)
		begin
			switch_force_closed <= overheat_shutdown_s &
				~fault_mask_config[fault_status_pkg::MSK_OVERHEAT_ACT];
			switch_force_open   <= overheat_shutdown_s &
				fault_mask_config[fault_status_pkg::MSK_OVERHEAT_ACT];
		end
	end

	// -----------------------------------------------------------------
	// Read data
	// -----------------------------------------------------------------
	// Captures the word before any read-clear of the same strobe.
	always_comb
	begin
		next_rdata = fault_status_pkg::ZERO_WORD;
		if (reg_addr == fault_status_pkg::ADDR_FAULT_MASK)
			next_rdata = fault_mask_config;
		else if (reg_addr == fault_status_pkg::ADDR_GENERAL_STATUS)
			next_rdata = general_status;
		else if (reg_addr == fault_status_pkg::ADDR_LAMP_OPEN)
			next_rdata[DRIVERS-1:0] = per_driver_lamp_open;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			reg_rdata <= fault_status_pkg::ZERO_WORD;
		else if (clk_en && reg_rd)
			reg_rdata <= next_rdata;
	end

endmodule : fault_status_mask

`default_nettype wire

// [bench/fault_status_mask_chk.sv]
// Purpose: Port-level assertions for the fault status block.
// Assumes: clk_en held high by the bench.
// Notes:   Bound onto the design from the bench top.
`timescale 1ns/1ns
`default_nettype none
module fault_status_mask_chk #(
	parameter int DRIVERS = 12
) (
	input wire logic                                clk,
	input wire logic                                srst,
	input wire logic                                clk_en,
	input wire logic                                reg_rd,
	input wire logic [fault_status_pkg::DATA_W-1:0] reg_rdata,
	input wire logic                                overheat_shutdown,
	input wire logic                                external_clock_slow,
	input wire logic [1:0]                          pwm_clock_select,
	input wire logic                                grade_read_done,
	input wire logic [DRIVERS-1:0]                  lamp_open_detect,
	input wire logic [DRIVERS-1:0]                  per_driver_lamp_open,
	input wire logic                                grade_valid,
	input wire logic                                fault_out_n,
	input wire logic                                fault_pin_out,
	input wire logic                                fault_pin_oe_n,
	input wire logic                                switch_force_closed,
	input wire logic                                switch_force_open
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// Three samples cover the two synchroniser stages
	sequence hot_run;
		(overheat_shutdown && clk_en)[*3];
	endsequence
	sequence cool_run;
		(!overheat_shutdown && clk_en)[*3];
	endsequence
	force_excl_a:
		assert property (!(switch_force_closed && switch_force_open))
		else $error("both switch forces high");
	force_pick_a:
		assert property (hot_run |-> ##1 switch_force_closed ^ switch_force_open)
		else $error("no switch force during shutdown");
	force_idle_a:
		assert property (cool_run |-> ##1 !switch_force_closed && !switch_force_open)
		else $error("switch force without shutdown");
	hot_fault_a:
		assert property (hot_run |-> ##[1:2] !fault_out_n)
		else $error("shutdown did not drive fault pin");
	slow_fault_a:
		assert property ((external_clock_slow && pwm_clock_select[1]
			&& clk_en)[*3] |-> ##[1:3] !fault_out_n)
		else $error("slow external clock did not drive fault pin");
	pin_mirror_a:
		assert property (fault_pin_oe_n == fault_out_n && !fault_pin_out)
		else $error("open-drain pin does not follow fault");
	rdata_hold_a:
		assert property (!(reg_rd && clk_en) |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	grade_rise_a:
		assert property ($rose(grade_valid) |-> $past(grade_read_done))
		else $error("grade valid without completion");
	grade_keep_a:
		assert property (grade_valid |=> grade_valid)
		else $error("grade valid dropped");
	lamp_set_a:
		assert property (clk_en && |lamp_open_detect |=>
			&(per_driver_lamp_open | ~$past(lamp_open_detect)))
		else $error("lamp open bit not set");
	lamp_keep_a:
		assert property (clk_en && !reg_rd |=>
			&(per_driver_lamp_open | ~$past(per_driver_lamp_open)))
		else $error("lamp open bit lost without read");
endmodule : fault_status_mask_chk
`default_nettype wire

// [bench/serial_master_model.sv]
// Purpose: Controller side issuing register strobes.
// Assumes: One strobe per access, set on the falling edge.
// Notes:   Idle write data is inverted so stale data is never reused.
`timescale 1ns/1ns
`default_nettype none
module serial_master_model (
	input  wire logic                                clk,
	input  wire logic [fault_status_pkg::DATA_W-1:0] reg_rdata,
	output var  logic                                reg_wr,
	output var  logic                                reg_rd,
	output var  logic [fault_status_pkg::ADDR_W-1:0] reg_addr,
	output var  logic [fault_status_pkg::DATA_W-1:0] reg_wdata
);
	initial
	begin
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 7'h00;
		reg_wdata = 13'h0000;
	end
	task automatic write_reg(input logic [6:0] a, input logic [12:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		@(negedge clk);
		reg_wr = 1'h0;
		reg_wdata = ~d;
	endtask : write_reg
	task automatic read_reg(input logic [6:0] a, output logic [12:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'h1;
		@(negedge clk);
		reg_rd = 1'h0;
		d = reg_rdata;
	endtask : read_reg
	// Busy poll is bounded so a stuck flag cannot hang the run
	task automatic write_config(input logic [12:0] d, output logic ok);
		logic [12:0] s;
		int          n;
		n = 0;
		read_reg(fault_status_pkg::ADDR_GENERAL_STATUS, s);
		while (s[9] !== 1'h0 && n < 50)
		begin
			read_reg(fault_status_pkg::ADDR_GENERAL_STATUS, s);
			n++;
		end
		ok = (s[9] === 1'h0);
		if (ok)
			write_reg(fault_status_pkg::ADDR_GENERAL_CONFIG, d);
	endtask : write_config
endmodule : serial_master_model
`default_nettype wire

// [bench/tb_fault_status_mask.sv]
// Purpose: Register-level tests of fault status and masking.
// Assumes: clk_en held high throughout.
// Notes:   Waits follow the fixed sync and register latencies.
`timescale 1ns/1ns
`default_nettype none
module tb_fault_status_mask;
	logic        clk, srst, clk_en, heat, hot, pump, slow, cfg_done, grd_done;
	logic [3:0]  serr;
	logic [11:0] brk, shrt, odet, lamp_open;
	logic [1:0]  csel;
	logic [12:0] rdata, rd, held;
	logic        grade_valid, fault_n, pin_out, pin_oe_n, f_closed, f_open;
	logic        reg_wr, reg_rd, ok;
	logic [6:0]  reg_addr;
	logic [12:0] reg_wdata;
	int          failures, checks_done, cycles, b;
	int          src[6] = '{0, 2, 3, 4, 5, 6};
	fault_status_mask fault_status_mask_inst (.clk, .srst, .clk_en,
		.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata(rdata),
		.heat_warning(heat), .overheat_shutdown(hot),
		.pump_not_ready(pump), .external_clock_slow(slow),
		.serial_read_error(serr[0]), .serial_write_error(serr[1]),
		.serial_checksum_error(serr[2]), .serial_clock_error(serr[3]),
		.per_driver_wiring_break(brk), .per_driver_lamp_short(shrt),
		.lamp_open_detect(odet), .pwm_clock_select(csel),
		.config_applied(cfg_done), .grade_read_done(grd_done),
		.per_driver_lamp_open(lamp_open), .grade_valid,
		.fault_out_n(fault_n), .fault_pin_out(pin_out),
		.fault_pin_oe_n(pin_oe_n), .switch_force_closed(f_closed),
		.switch_force_open(f_open));
	serial_master_model serial_master_model_inst (.clk, .reg_rdata(rdata),
		.reg_wr, .reg_rd, .reg_addr, .reg_wdata);
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic complete_run();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			complete_run();
		end
	end
	task automatic check_word(string n, logic [12:0] e, logic [12:0] g);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : check_word
	task automatic check_bit(string n, logic e, logic g);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
		end
	endtask : check_bit
	task automatic rd_chk(logic [6:0] a, logic [12:0] e, string n);
		serial_master_model_inst.read_reg(a, rd);
		check_word(n, e, rd);
	endtask : rd_chk
	task automatic wr(logic [6:0] a, logic [12:0] d);
		serial_master_model_inst.write_reg(a, d);
	endtask : wr
	task automatic wait_n(int n);
		repeat (n) @(negedge clk);
	endtask : wait_n
	task automatic set_src(int s, logic v);
		@(negedge clk);
		case (s)
			0: heat = v;
			2: pump = v;
			3: shrt[3] = v;
			4: odet[0] = v;
			5: brk[11] = v;
			default: serr[0] = v;
		endcase
	endtask : set_src
	initial
	begin
		{srst, clk_en, cfg_done, grd_done} = 4'hC;
		{heat, hot, pump, slow, serr, csel} = 10'h000;
		{brk, shrt, odet} = 36'h0;
		wait_n(20);
		srst = 1'h0;
		rd_chk(7'h04, 13'h0000, "mask reset");
		rd_chk(7'h05, 13'h0100, "status reset");
		rd_chk(7'h10, 13'h0000, "unmapped");
		wr(7'h04, 13'h1FFF);
		rd_chk(7'h04, 13'h007F, "mask used bits");
		wr(7'h05, 13'h1FFF);
		rd_chk(7'h05, 13'h0100, "status write ignored");
		$display("register access done");
		foreach (src[i])
		begin
			b = src[i];
			wr(7'h04, 13'h0000);
			set_src(b, 1'h1);
			wait_n(5);
			check_bit("pin unmasked", 1'h0, fault_n);
			wr(7'h04, 13'h0001 << b);
			wait_n(3);
			check_bit("pin masked", 1'h1, fault_n);
			held = 13'h0001 << b;
			rd_chk(7'h05, 13'h0100 | held, "status live");
			set_src(b, 1'h0);
			wait_n(4);
			// Only the warning latch and the lamp-open word outlive the source
			held = (b == 0 || b == 4) ? held : 13'h0000;
			rd_chk(7'h05, 13'h0100 | held, "status after clear");
			rd_chk(7'h06, {12'h000, b == 4}, "lamp open clear");
			rd_chk(7'h05, 13'h0100, "status cleared");
			wr(7'h04, 13'h0000);
			wait_n(3);
			check_bit("pin released", 1'h1, fault_n);
		end
		for (int k = 0; k < 4; k++)
		begin
			serr[k] = 1'h1;
			rd_chk(7'h05, 13'h0140, "serial error or");
			serr[k] = 1'h0;
		end
		$display("mask table done");
		hot = 1'h1;
		wait_n(5);
		check_bit("force closed", 1'h1, f_closed);
		check_bit("overheat pin", 1'h0, fault_n);
		check_bit("pin drive", 1'h0, pin_oe_n);
		wr(7'h04, 13'h0002);
		wait_n(2);
		check_bit("force open", 1'h1, f_open);
		rd_chk(7'h05, 13'h0102, "overheat set");
		rd_chk(7'h05, 13'h0102, "overheat held");
		hot = 1'h0;
		wait_n(5);
		check_bit("force off", 1'h0, f_open);
		rd_chk(7'h05, 13'h0102, "overheat latched");
		rd_chk(7'h05, 13'h0100, "overheat cleared");
		wr(7'h04, 13'h0000);
		$display("overheat done");
		slow = 1'h1;
		for (int s = 0; s < 4; s++)
		begin
			csel = s[1:0];
			wait_n(4);
			rd_chk(7'h05, {5'h01, s[1], 7'h00}, "clock too slow");
		end
		{slow, csel} = 3'h0;
		serial_master_model_inst.write_config(13'h0001, ok);
		check_bit("config poll", 1'h1, ok);
		rd_chk(7'h05, 13'h0300, "config busy");
		check_bit("busy no fault", 1'h1, fault_n);
		cfg_done = 1'h1;
		wait_n(1);
		cfg_done = 1'h0;
		rd_chk(7'h05, 13'h0100, "config done");
		serial_master_model_inst.write_config(13'h0002, ok);
		check_bit("config poll", 1'h1, ok);
		grd_done = 1'h1;
		wait_n(1);
		grd_done = 1'h0;
		wait_n(1);
		check_bit("grade valid", 1'h1, grade_valid);
		rd_chk(7'h05, 13'h0200, "grade ready");
		// Busy still set: the write must wait for the done pulse
		fork
			serial_master_model_inst.write_config(13'h0003, ok);
			begin
				wait_n(8);
				cfg_done = 1'h1;
				wait_n(1);
				cfg_done = 1'h0;
			end
		join
		check_bit("config poll wait", 1'h1, ok);
		rd_chk(7'h05, 13'h0200, "config rewrite busy");
		odet = 12'h801;
		wait_n(1);
		odet = 12'h000;
		check_word("lamp open port", 13'h0801, {1'h0, lamp_open});
		rd_chk(7'h06, 13'h0801, "lamp open word");
		rd_chk(7'h06, 13'h0000, "lamp open read clear");
		$display("config grade lamp done");
		complete_run();
	end
endmodule : tb_fault_status_mask
bind fault_status_mask fault_status_mask_chk #(.DRIVERS(DRIVERS)) chk_inst (
	.clk, .srst, .clk_en, .reg_rd, .reg_rdata, .overheat_shutdown,
	.external_clock_slow, .pwm_clock_select, .grade_read_done,
	.lamp_open_detect, .per_driver_lamp_open, .grade_valid, .fault_out_n,
	.fault_pin_out, .fault_pin_oe_n, .switch_force_closed,
	.switch_force_open);
`default_nettype wire
